/* File: hw/adgc_map.svh */
/*
  Register offsets, field positions and reset values of the auxiliary
  converter and pin control block. Assumes 7-bit byte addresses as carried
  in the first byte of each serial frame.
*/
`ifndef ADGC_MAP_SVH
`define ADGC_MAP_SVH

`define ADGC_OFF_ADC      7'h0A
`define ADGC_OFF_DAC      7'h30
`define ADGC_OFF_PIN      7'h32
`define ADGC_OFF_MISC     7'h34
`define ADGC_OFF_CMD      7'h3E

`define ADGC_RST_DAC      12'h0000
`define ADGC_RST_PIN      2'b00
`define ADGC_CODE_W       12

`define ADGC_PIN_DIR0     9
`define ADGC_PIN_DIR1     8
`define ADGC_PIN_LVL0     1
`define ADGC_PIN_LVL1     0

`define ADGC_MISC_ST      8
`define ADGC_MISC_DR_EN   2
`define ADGC_MISC_DR_POL  1
`define ADGC_MISC_DR_SEL  0

`define ADGC_CMD_LATCH    2
`define ADGC_CMD_SWRST    7

`define ADGC_FRAME_BITS   4'h0F

`endif

/* File: hw/adgc_pkg.sv */
/*
  Types shared by the auxiliary converter and pin control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package adgc_pkg;

  typedef logic [6:0]  adgc_addr_t;
  typedef logic [15:0] adgc_word_t;

  typedef enum logic [0:0] {
    ADGC_SPI_IDLE  = 1'b0,
    ADGC_SPI_SHIFT = 1'b1
  } adgc_spi_state_t;

endpackage

/* File: hw/adgc_spi_slave.sv */
/*
  Serial slave port: 16-bit frames, first byte write flag and address,
  second byte data, MSB first. Assumes the serial clock is far slower than clk
  (at least eight clk periods per serial half period).
*/
`timescale 1ns/1ps
`include "adgc_map.svh"

module adgc_spi_slave (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               sclk,
  input  wire logic               cs_n,
  input  wire logic               din,
  input  wire adgc_pkg::adgc_word_t rd_word,
  output logic                    dout,
  output logic                    dout_oe,
  output logic                    wr_pulse,
  output logic                    rd_pulse,
  output adgc_pkg::adgc_addr_t    acc_addr,
  output logic [7:0]              wr_data
);

  // bit 2 sclk, bit 1 cs_n, bit 0 din
  logic [2:0]                s1_q, s2_q, s3_q, filt_q, filt_d;
  adgc_pkg::adgc_spi_state_t state_q, state_d;
  logic [3:0]                cnt_q, cnt_d;
  logic [15:0]               rx_q, rx_d, tx_q, tx_d;
  logic                      wr_q, wr_d, rd_q, rd_d;
  adgc_pkg::adgc_addr_t      addr_q, addr_d;
  logic [7:0]                data_q, data_d;
  logic                      sclk_rise, sclk_fall, cs_low;

  always_comb begin
    filt_d = filt_q;
    for (int i = 0; i < 3; i++) begin
      // only a level held by both later stages counts
      if (s2_q[i] == s3_q[i]) begin
        filt_d[i] = s3_q[i];
      end
    end
    sclk_rise = ~filt_q[2] & filt_d[2];
    sclk_fall = filt_q[2] & ~filt_d[2];
    cs_low    = ~filt_d[1];
    state_d   = state_q;
    cnt_d     = cnt_q;
    rx_d      = rx_q;
    tx_d      = tx_q;
    wr_d      = 1'b0;
    rd_d      = 1'b0;
    addr_d    = addr_q;
    data_d    = data_q;
    if (rd_q) begin
      tx_d = rd_word;
    end
    case (state_q)
      adgc_pkg::ADGC_SPI_IDLE: begin
        cnt_d = 4'h0;
        if (cs_low) begin
          state_d = adgc_pkg::ADGC_SPI_SHIFT;
        end
      end
      adgc_pkg::ADGC_SPI_SHIFT: begin
        if (!cs_low) begin
          state_d = adgc_pkg::ADGC_SPI_IDLE;
          cnt_d   = 4'h0;
        end else if (sclk_rise) begin
          rx_d  = {rx_q[14:0], filt_d[0]};
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == `ADGC_FRAME_BITS) begin
            wr_d   = rx_d[15];
            rd_d   = ~rx_d[15];
            addr_d = rx_d[14:8];
            data_d = rx_d[7:0];
            tx_d   = 16'h0000;
          end
        end else if (sclk_fall && cnt_q != 4'h0) begin
          // first fall of a word keeps the MSB already on the pin
          tx_d = {tx_q[14:0], 1'b0};
        end
      end
      default: begin
        state_d = adgc_pkg::ADGC_SPI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q    <= 3'b110;
      s2_q    <= 3'b110;
      s3_q    <= 3'b110;
      filt_q  <= 3'b110;
      state_q <= adgc_pkg::ADGC_SPI_IDLE;
      cnt_q   <= 4'h0;
      rx_q    <= 16'h0000;
      tx_q    <= 16'h0000;
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      addr_q  <= 7'h00;
      data_q  <= 8'h00;
    end else begin
      s1_q    <= {sclk, cs_n, din};
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      filt_q  <= filt_d;
      state_q <= state_d;
      cnt_q   <= cnt_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      addr_q  <= addr_d;
      data_q  <= data_d;
    end
  end

  assign dout     = tx_q[15];
  assign dout_oe  = (state_q == adgc_pkg::ADGC_SPI_SHIFT);
  assign wr_pulse = wr_q;
  assign rd_pulse = rd_q;
  assign acc_addr = addr_q;
  assign wr_data  = data_q;

endmodule // adgc_spi_slave

/* File: hw/adgc_aux_dac_gpio_control.sv */
/*
  Auxiliary converter code registers and two general purpose pins with a
  fixed priority owner mux, reached over the serial slave port.
  Assumes the alarm logic and data-ready source live outside and run on clk.
*/
//
// Summary of operation
// - The auxiliary input result reads as unsigned 12-bit straight binary, zero is 0 V.
// - The output code is staged byte by byte and the converter only moves on latch or reset.
// - Writing one to bit 2 of the command register copies the staged code to the latch.
// - The output code register holds bits 11:0 at bytes 0x30 and 0x31, upper bits unused.
// - The output code maps linearly, code zero to 0 V and 0x0FFF to 2.5 V full scale.
// - The output code register is volatile and every reset clears it to zero.
// - Two bidirectional pins have direction and level set by the pin control register.
// - Pin control bit 9 sets line zero direction and bit 8 line one, one meaning output.
// - Pin control bit 1 sets line zero level and bit 0 line one level.
// - Data-ready owns a pin before the alarm, and the alarm before plain pin control.
// - The pin control register is cleared on reset, leaving both pins as inputs.
// - Pin control sits at bytes 0x32 and 0x33 with bits 15:10 and 7:2 unused.
// - Misc control bit 2 enables data-ready, bit 1 sets active high, bit 0 picks line one.
`timescale 1ns/1ps
`include "adgc_map.svh"

module adgc_aux_dac_gpio_control #(
  parameter int CODE_W = `ADGC_CODE_W
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              din,
  output logic                   dout,
  output logic                   dout_oe,
  input  wire logic [CODE_W-1:0] adc_code,
  output logic [CODE_W-1:0]      dac_code,
  output logic                   self_test,
  input  wire logic              data_ready,
  input  wire logic              alarm_active,
  input  wire logic              alarm_pin_en,
  input  wire logic              alarm_pin_sel,
  input  wire logic              alarm_pin_pol,
  input  wire logic              io_line_zero_i,
  output logic                   io_line_zero_o,
  output logic                   io_line_zero_oe,
  input  wire logic              io_line_one_i,
  output logic                   io_line_one_o,
  output logic                   io_line_one_oe
);

  logic                 wr_pulse, rd_pulse;
  adgc_pkg::adgc_addr_t acc_addr;
  logic [7:0]           wr_data;
  adgc_pkg::adgc_word_t rd_word;

  adgc_spi_slave u_spi (
    .clk      (clk),
    .reset    (reset),
    .sclk     (sclk),
    .cs_n     (cs_n),
    .din      (din),
    .rd_word  (rd_word),
    .dout     (dout),
    .dout_oe  (dout_oe),
    .wr_pulse (wr_pulse),
    .rd_pulse (rd_pulse),
    .acc_addr (acc_addr),
    .wr_data  (wr_data)
  );

  // index 0 is line zero, index 1 is line one
  logic [CODE_W-1:0] stage_q, stage_d, latch_q, latch_d;
  logic [1:0]        dir_q, dir_d, lvl_q, lvl_d;
  logic              st_q, st_d, dr_en_q, dr_en_d, dr_pol_q, dr_pol_d, dr_sel_q, dr_sel_d;
  logic [1:0]        ps1_q, ps2_q, ps3_q, pin_f_q, pin_f_d;
  logic [1:0]        pin_o_q, pin_o_d, pin_oe_q, pin_oe_d;
  logic              hi_byte, soft_rst;
  logic [6:0]        word_addr;

  always_comb begin
    hi_byte   = acc_addr[0];
    // both bytes of a register share one even word address
    word_addr = {acc_addr[6:1], 1'b0};
    stage_d   = stage_q;
    latch_d   = latch_q;
    dir_d     = dir_q;
    lvl_d     = lvl_q;
    st_d      = st_q;
    dr_en_d   = dr_en_q;
    dr_pol_d  = dr_pol_q;
    dr_sel_d  = dr_sel_q;
    soft_rst  = 1'b0;
    if (wr_pulse) begin
      case (word_addr)
        `ADGC_OFF_DAC: begin
          // staging only; the converter keeps its old code meanwhile
          if (hi_byte) begin
            stage_d[CODE_W-1:8] = wr_data[CODE_W-9:0];
          end else begin
            stage_d[7:0] = wr_data;
          end
        end
        `ADGC_OFF_PIN: begin
          if (hi_byte) begin
            dir_d[0] = wr_data[`ADGC_PIN_DIR0 - 8];
            dir_d[1] = wr_data[`ADGC_PIN_DIR1 - 8];
          end else begin
            lvl_d[0] = wr_data[`ADGC_PIN_LVL0];
            lvl_d[1] = wr_data[`ADGC_PIN_LVL1];
          end
        end
        `ADGC_OFF_MISC: begin
          if (hi_byte) begin
            st_d = wr_data[`ADGC_MISC_ST - 8];
          end else begin
            dr_en_d  = wr_data[`ADGC_MISC_DR_EN];
            dr_pol_d = wr_data[`ADGC_MISC_DR_POL];
            dr_sel_d = wr_data[`ADGC_MISC_DR_SEL];
          end
        end
        `ADGC_OFF_CMD: begin
          // command bits act once and read back as zero
          if (!hi_byte && wr_data[`ADGC_CMD_LATCH]) begin
            latch_d = stage_q;
          end
          if (!hi_byte && wr_data[`ADGC_CMD_SWRST]) begin
            soft_rst = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // software reset clears volatile state; data-ready setup survives it
    if (soft_rst) begin
      stage_d = `ADGC_RST_DAC;
      latch_d = `ADGC_RST_DAC;
      dir_d   = `ADGC_RST_PIN;
      lvl_d   = `ADGC_RST_PIN;
      st_d    = 1'b0;
    end
  end

  // owner priority: data-ready, then alarm, then plain pin control
  always_comb begin
    pin_f_d  = pin_f_q;
    // released unless a branch below claims the line
    pin_oe_d = 2'h0;
    pin_o_d  = 2'h0;
    for (int i = 0; i < 2; i++) begin
      if (ps2_q[i] == ps3_q[i]) begin
        pin_f_d[i] = ps3_q[i];
      end
      if (dr_en_q && dr_sel_q == i[0]) begin
        pin_oe_d[i] = 1'b1;
        pin_o_d[i]  = dr_pol_q ? data_ready : ~data_ready;
      end else if (alarm_pin_en && alarm_pin_sel == i[0]) begin
        pin_oe_d[i] = 1'b1;
        pin_o_d[i]  = alarm_pin_pol ? alarm_active : ~alarm_active;
      end else begin
        pin_oe_d[i] = dir_q[i];
        pin_o_d[i]  = dir_q[i] & lvl_q[i];
      end
    end
  end

  always_comb begin
    case (word_addr)
      `ADGC_OFF_ADC: rd_word = {{(16-CODE_W){1'b0}}, adc_code};
      `ADGC_OFF_DAC: rd_word = {{(16-CODE_W){1'b0}}, stage_q};
      // input lines read their pin, output lines their level bit
      `ADGC_OFF_PIN: rd_word = {6'h00, dir_q[0], dir_q[1], 6'h00,
                                dir_q[0] ? lvl_q[0] : pin_f_q[0],
                                dir_q[1] ? lvl_q[1] : pin_f_q[1]};
      `ADGC_OFF_MISC: rd_word = {7'h00, st_q, 5'h00, dr_en_q, dr_pol_q, dr_sel_q};
      default: rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stage_q  <= `ADGC_RST_DAC;
      latch_q  <= `ADGC_RST_DAC;
      dir_q    <= `ADGC_RST_PIN;
      lvl_q    <= `ADGC_RST_PIN;
      st_q     <= 1'b0;
      dr_en_q  <= 1'b0;
      dr_pol_q <= 1'b0;
      dr_sel_q <= 1'b0;
      // pins idle high through their pull-ups
      ps1_q    <= 2'b11;
      ps2_q    <= 2'b11;
      ps3_q    <= 2'b11;
      pin_f_q  <= 2'b11;
      pin_o_q  <= 2'b00;
      pin_oe_q <= 2'b00;
    end else begin
      stage_q  <= stage_d;
      latch_q  <= latch_d;
      dir_q    <= dir_d;
      lvl_q    <= lvl_d;
      st_q     <= st_d;
      dr_en_q  <= dr_en_d;
      dr_pol_q <= dr_pol_d;
      dr_sel_q <= dr_sel_d;
      ps1_q    <= {io_line_one_i, io_line_zero_i};
      ps2_q    <= ps1_q;
      ps3_q    <= ps2_q;
      pin_f_q  <= pin_f_d;
      pin_o_q  <= pin_o_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  // linear code to the analog stage, full scale at all ones
  assign dac_code        = latch_q;
  assign self_test       = st_q;
  assign io_line_zero_o  = pin_o_q[0];
  assign io_line_zero_oe = pin_oe_q[0];
  assign io_line_one_o   = pin_o_q[1];
  assign io_line_one_oe  = pin_oe_q[1];

endmodule // adgc_aux_dac_gpio_control

/* File: dv/adgc_aux_dac_gpio_control_assertions.sv */
/*
  Port-level assertions for the aux converter and pin control block.
  Assumes binding into adgc_aux_dac_gpio_control with synchronous reset.
*/
`timescale 1ns/1ps
module adgc_checker #(
  parameter int CODE_W = 12
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              cs_n,
  input wire logic [CODE_W-1:0] dac_code,
  input wire logic              alarm_pin_en,
  input wire logic              alarm_pin_sel,
  input wire logic              io_line_zero_o,
  input wire logic              io_line_zero_oe,
  input wire logic              io_line_one_o,
  input wire logic              io_line_one_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // long enough for any write in flight to land
  sequence cs_idle;
    cs_n [*8] ##1 cs_n [*4];
  endsequence

  a_reset_clears_dac: assert property ($fell(reset) |-> dac_code == '0)
    else $error("dac code not cleared by reset");
  a_reset_pins_in: assert property ($fell(reset) |-> !io_line_zero_oe && !io_line_one_oe)
    else $error("pin driven after reset");
  a_reset_pins_low: assert property ($fell(reset) |-> !io_line_zero_o && !io_line_one_o)
    else $error("pin level high after reset");
  a_dac_holds_idle: assert property (cs_idle |=> $stable(dac_code))
    else $error("dac code moved without serial traffic");
  a_alarm_owns_zero: assert property (alarm_pin_en && !alarm_pin_sel |=> io_line_zero_oe)
    else $error("alarm did not claim line zero");
  a_alarm_owns_one: assert property (alarm_pin_en && alarm_pin_sel |=> io_line_one_oe)
    else $error("alarm did not claim line one");
  a_idle_zero_low: assert property (!io_line_zero_oe |-> !io_line_zero_o)
    else $error("released line zero carries a level");
  a_idle_one_low: assert property (!io_line_one_oe |-> !io_line_one_o)
    else $error("released line one carries a level");
endmodule // adgc_checker

bind adgc_aux_dac_gpio_control adgc_checker #(.CODE_W(CODE_W)) u_chk (
  .clk, .reset, .cs_n, .dac_code, .alarm_pin_en, .alarm_pin_sel,
  .io_line_zero_o, .io_line_zero_oe, .io_line_one_o, .io_line_one_oe
);

/* File: dv/tb.sv */
/*
  Self-checking bench for the aux converter and pin control block.
  Assumes the serial port wants at least eight clk per sclk half period.
*/
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        sclk = 1'b1;
  logic        cs_n = 1'b1;
  logic        din = 1'b0;
  logic [11:0] adc_code = 12'ha5c;
  logic        data_ready = 1'b0;
  logic        alarm_active = 1'b0;
  logic        alarm_pin_en = 1'b0;
  logic        alarm_pin_sel = 1'b0;
  logic        alarm_pin_pol = 1'b0;
  logic        dout, dout_oe, self_test;
  logic [11:0] dac_code;
  logic        io_line_zero_o, io_line_zero_oe, io_line_one_o, io_line_one_oe;
  // outside level on released pins, high through the pull-up by default
  logic [1:0]  ext_lvl = 2'h3;
  wire logic   io_line_zero_i = io_line_zero_oe ? io_line_zero_o : ext_lvl[0];
  wire logic   io_line_one_i = io_line_one_oe ? io_line_one_o : ext_lvl[1];
  int          error_cnt = 0;
  int          compares = 0;

  always #12.5 clk = ~clk;

  adgc_aux_dac_gpio_control dut (
    .clk, .reset, .sclk, .cs_n, .din, .dout, .dout_oe, .adc_code, .dac_code, .self_test,
    .data_ready, .alarm_active, .alarm_pin_en, .alarm_pin_sel, .alarm_pin_pol,
    .io_line_zero_i, .io_line_zero_o, .io_line_zero_oe,
    .io_line_one_i, .io_line_one_o, .io_line_one_oe
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic word(input logic [15:0] w, output logic [15:0] r);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      din  <= w[i];
      repeat (8) @(posedge clk);
      sclk <= 1'b1;
      r[i] = dout;
      repeat (8) @(posedge clk);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    word({1'b1, a, d}, r);
    cs_n <= 1'b1;
    repeat (16) @(posedge clk);
  endtask

  // reply to a read arrives in the following word
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] r;
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    word({1'b0, a, 8'h00}, r);
    word(16'h0000, r);
    check({15'h0000, dout_oe}, 16'h0001);
    cs_n <= 1'b1;
    repeat (16) @(posedge clk);
    check({15'h0000, dout_oe}, 16'h0000);
    check(r, exp);
  endtask

  task automatic pins(input logic [3:0] exp);
    check({12'h000, io_line_zero_oe, io_line_zero_o, io_line_one_oe, io_line_one_o},
          {12'h000, exp});
  endtask

  task automatic t_reset_state();
    check({4'h0, dac_code}, 16'h0000);
    pins(4'b0000);
    check({15'h0000, self_test}, 16'h0000);
    rd(7'h30, 16'h0000);
    rd(7'h32, 16'h0003);
    rd(7'h0a, 16'h0a5c);
    rd(7'h2e, 16'h0000);
  endtask

  task automatic t_dac_stage();
    wr(7'h30, 8'h34);
    wr(7'h31, 8'hab);
    check({4'h0, dac_code}, 16'h0000);
    rd(7'h31, 16'h0b34);
    wr(7'h3e, 8'h04);
    check({4'h0, dac_code}, 16'h0b34);
    wr(7'h30, 8'hff);
    wr(7'h31, 8'h0f);
    check({4'h0, dac_code}, 16'h0b34);
    wr(7'h3e, 8'h04);
    check({4'h0, dac_code}, 16'h0fff);
  endtask

  task automatic t_pin_ctrl();
    wr(7'h33, 8'h03);
    wr(7'h32, 8'h02);
    pins(4'b1110);
    rd(7'h32, 16'h0302);
    wr(7'h32, 8'hfd);
    wr(7'h33, 8'hfe);
    pins(4'b1000);
    rd(7'h33, 16'h0201);
    ext_lvl <= 2'h1;
    rd(7'h32, 16'h0200);
    ext_lvl <= 2'h3;
  endtask

  task automatic t_priority();
    alarm_pin_en  <= 1'b1;
    alarm_pin_pol <= 1'b1;
    alarm_active  <= 1'b1;
    repeat (4) @(posedge clk);
    pins(4'b1100);
    wr(7'h34, 8'h06);
    pins(4'b1000);
    data_ready <= 1'b1;
    repeat (4) @(posedge clk);
    pins(4'b1100);
    wr(7'h34, 8'h05);
    pins(4'b1110);
  endtask

  // command soft reset wins over a latch in the same write
  task automatic t_soft_reset();
    alarm_pin_sel <= 1'b1;
    wr(7'h34, 8'h00);
    pins(4'b1011);
    wr(7'h35, 8'h01);
    wr(7'h34, 8'h06);
    check({15'h0000, self_test}, 16'h0001);
    rd(7'h34, 16'h0106);
    pins(4'b1111);
    wr(7'h3e, 8'h84);
    check({4'h0, dac_code}, 16'h0000);
    check({15'h0000, self_test}, 16'h0000);
    rd(7'h34, 16'h0006);
    pins(4'b1111);
    rd(7'h32, 16'h0003);
    rd(7'h30, 16'h0000);
  endtask

  task automatic t_mid_reset();
    wr(7'h34, 8'h00);
    wr(7'h30, 8'h5a);
    wr(7'h3e, 8'h04);
    check({4'h0, dac_code}, 16'h005a);
    alarm_pin_en <= 1'b0;
    reset        <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    check({4'h0, dac_code}, 16'h0000);
    pins(4'b0000);
    rd(7'h30, 16'h0000);
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    t_reset_state();
    t_dac_stage();
    t_pin_ctrl();
    t_priority();
    t_soft_reset();
    t_mid_reset();
    complete_run();
  end

  // whole run needs about 12300 cycles
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule // tb
